//--- rtl/pcstk_pkg.sv
`default_nettype none
package pcstk_pkg;
   localparam logic [11:0] IDX_FLAGS_COPY = 12'hFE4;
   localparam logic [11:0] IDX_ACCUM_COPY = 12'hFE5;
   localparam logic [11:0] IDX_BANK_COPY = 12'hFE6;
   localparam logic [11:0] IDX_LATCH_COPY = 12'hFE7;
   localparam logic [11:0] IDX_PTR0L_COPY = 12'hFE8;
   localparam logic [11:0] IDX_PTR0H_COPY = 12'hFE9;
   localparam logic [11:0] IDX_PTR1L_COPY = 12'hFEA;
   localparam logic [11:0] IDX_PTR1H_COPY = 12'hFEB;
   localparam logic [11:0] IDX_UNUSED = 12'hFEC;
   localparam logic [11:0] IDX_STACK_INDEX = 12'hFED;
   localparam logic [11:0] IDX_TOS_LOW = 12'hFEE;
   localparam logic [11:0] IDX_TOS_HIGH = 12'hFEF;
   localparam logic [11:0] IDX_PC_LOW = 12'hFF0;
   localparam logic [11:0] IDX_PC_LATCH = 12'hFF1;
   localparam logic [11:0] IDX_POWER_CTRL = 12'hFF2;
   localparam logic [11:0] IDX_STACK_CFG = 12'hFF3;
   localparam logic [4:0] STACK_EMPTY = 5'h1F;
   localparam logic [4:0] STACK_FIRST = 5'h00;
   localparam logic [4:0] STACK_LAST = 5'h0F;
   localparam logic [14:0] PC_RESET = 15'h0000;
   localparam logic [6:0] LATCH_RESET = 7'h00;
   localparam logic [1:0] PWR_RESET = 2'h0;
   localparam logic CFG_RESET = 1'b0;
   localparam int POS_OVF = 0;
   localparam int POS_UNF = 1;
   localparam logic [15:0] TRAD_LAST = 16'h0FFF;
   localparam logic [15:0] LIN_BASE = 16'h2000;
   localparam logic [15:0] LIN_LAST = 16'h29AF;
   localparam logic [11:0] GPR_LEN = 12'h050;
   localparam logic [6:0] GPR_BASE = 7'h20;
   localparam logic [6:0] WINDOW0 = 7'h00;
   localparam logic [6:0] WINDOW1 = 7'h01;
   localparam logic [4:0] LIN_BANKS_IMPL = 5'h08;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [3:0] {
      OP_NONE, OP_STEP, OP_WRITE_LOW, OP_CALL, OP_CALL_VIA_ACCUM, OP_BRW, OP_BRA,
      OP_VECTOR, OP_RETURN, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT
   } pc_op_t;
   typedef enum logic {IND_IDLE, IND_FLASH} ind_state_t;
   typedef struct packed {
      logic [7:0] flags;
      logic [7:0] accum;
      logic [7:0] bank;
      logic [7:0] latch;
      logic [15:0] ptr0;
      logic [15:0] ptr1;
   } ctx_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } ind_req_t;
   localparam ctx_t CTX_RESET = '0;
endpackage
`default_nettype wire

//--- rtl/pc_stack_indirect_addressing.sv
// What this block does
// - Keeps a 15-bit program counter; low byte readable, upper seven from high latch.
// - Every reset clears the whole program counter.
// - Writing the low byte loads the upper seven bits from the latch together.
// - Direct call takes eleven operand bits; top four bits come from latch bits 6:3.
// - Accumulator call loads low byte from accumulator and high bits from latch.
// - Accumulator branch sets counter to counter plus one plus unsigned accumulator.
// - Operand branch adds one plus sign-extended operand; page crossing allowed.
// - Return stack has sixteen 15-bit entries outside program and data spaces.
// - Calls and vectoring push, returns pop; only return from interrupt touches the high latch, restoring it.
// - With fault reset off the stack is circular; extra pushes overwrite oldest.
// - Overflow and underflow flags are set whether or not fault reset is on.
// - A 5-bit stack index positions a read/write top-of-stack register pair.
// - Push increments index then stores; pop reloads counter then decrements.
// - Index 0x1F means empty, holds after reset, and returns after last pop.
// - With fault reset on, overflow or underflow resets and records the flag.
// - Window access through a pointer to a window reads zero and never writes.
// - Pointer addresses 0x000 to 0xFFF map straight onto banked data memory.
// - Pointer 0x2000 to 0x29AF walks the 80-byte RAM blocks bank after bank.
// - Unimplemented locations in the linear RAM region read 0x00.
// - Pointer top bit set selects flash; low eight bits returned, writes ignored.
// - Flash access through the window takes one extra cycle.
`default_nettype none
module pc_stack_indirect_addressing (
   input wire logic aclk,
   input wire logic aresetn,
   input wire pcstk_pkg::pc_op_t op,
   input wire logic [14:0] op_arg,
   input wire logic [7:0] accum,
   input wire logic latch_we,
   input wire logic [7:0] latch_wdata,
   input wire pcstk_pkg::ctx_t ctx_in,
   output logic [14:0] pc,
   output logic [6:0] pc_high_latch,
   output var pcstk_pkg::ctx_t ctx_out,
   output logic ctx_restore,
   output logic stack_fault_reset,
   input wire pcstk_pkg::ind_req_t ind_req,
   output logic ind_ready,
   output logic ind_done,
   output logic [7:0] ind_rdata,
   output logic [11:0] mem_addr,
   output logic mem_we,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   output logic [14:0] flash_addr,
   input wire logic [13:0] flash_rdata,
   input wire logic [15:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [15:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   import pcstk_pkg::*;

   logic [14:0] pc_q, pc_d;
   logic [6:0] latch_q, latch_d;
   logic [4:0] idx_q, idx_d;
   logic [14:0] stack_q [16];
   logic [1:0] pwr_q, pwr_d;
   logic opt_q;
   ctx_t ctx_q, ctx_d;
   logic restore_q, fault_q;
   logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
   logic [15:0] awaddr_q;
   logic [7:0] wbyte_q;
   logic lane0_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q, rd_word;
   ind_state_t ind_state_q;
   logic ind_done_q, flash_wr_q;
   logic [7:0] ind_rdata_q;
   logic [14:0] flash_addr_q;

   function automatic logic is_mapped(input logic [15:0] a);
      logic [11:0] i;
      i = a[13:2];
      return (a[15:14] == 2'h0) && (i >= IDX_FLAGS_COPY) && (i <= IDX_STACK_CFG)
         && (i != IDX_UNUSED);
   endfunction

   // Register bus: write address and data are held until both have arrived
   wire aw_take = awvalid && awready;
   wire w_take = wvalid && wready;
   wire ar_take = arvalid && arready;
   wire do_write = aw_hold_q && w_hold_q && !bvalid_q;
   wire wr_ok = do_write && lane0_q && is_mapped(awaddr_q);
   wire [11:0] widx = awaddr_q[13:2];
   wire wr_ctx = wr_ok && (op != OP_VECTOR);
   assign awready = !aw_hold_q;
   assign wready = !w_hold_q;
   assign arready = !rvalid_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;

   // Stack events; the core owns the stack in any cycle it pushes or pops
   wire push = (op == OP_CALL) || (op == OP_CALL_VIA_ACCUM) || (op == OP_VECTOR);
   wire pop = (op == OP_RETURN) || (op == OP_RETURN_WITH_LITERAL) || (op == OP_RETURN_FROM_INTERRUPT);
   wire ovf = push && (idx_q == STACK_LAST);
   wire unf = pop && (idx_q == STACK_EMPTY);
   wire fault = (ovf || unf) && opt_q;
   wire [4:0] push_idx = (idx_q == STACK_EMPTY) ? STACK_FIRST
      : {1'b0, 4'(idx_q[3:0] + 4'h1)};
   wire [4:0] pop_idx = (idx_q == STACK_FIRST) ? STACK_EMPTY
      : unf ? STACK_LAST : 5'(idx_q - 5'h01);
   wire [14:0] tos_word = stack_q[idx_q[3:0]];
   wire [14:0] pc_inc = 15'(pc_q + 15'h0001);
   wire [14:0] ret_addr = (op == OP_VECTOR) ? pc_q : pc_inc;
   wire [14:0] bra_ofs = {{6{op_arg[8]}}, op_arg[8:0]};
   wire tos_lo_wr = wr_ok && (widx == IDX_TOS_LOW) && !push && !pop;
   wire tos_hi_wr = wr_ok && (widx == IDX_TOS_HIGH) && !push && !pop;

   always_comb begin
      pc_d = pc_q;
      case (op)
         OP_STEP: pc_d = pc_inc;
         OP_WRITE_LOW: pc_d = {latch_q, op_arg[7:0]};
         OP_CALL: pc_d = {latch_q[6:3], op_arg[10:0]};
         OP_CALL_VIA_ACCUM: pc_d = {latch_q, accum};
         OP_BRW: pc_d = 15'(pc_inc + {7'h00, accum});
         OP_BRA: pc_d = 15'(pc_inc + bra_ofs);
         OP_VECTOR: pc_d = op_arg;
         OP_RETURN, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT: pc_d = tos_word;
         OP_NONE: begin
            if (wr_ok && (widx == IDX_PC_LOW)) begin
               pc_d = {latch_q, wbyte_q};
            end
         end
         default: pc_d = pc_q;
      endcase
      if (fault) begin
         pc_d = PC_RESET;
      end
   end

   always_comb begin
      idx_d = idx_q;
      if (push) begin
         idx_d = push_idx;
      end else if (pop) begin
         idx_d = pop_idx;
      end else if (wr_ok && (widx == IDX_STACK_INDEX)) begin
         idx_d = wbyte_q[4:0];
      end
      if (fault) begin
         idx_d = STACK_EMPTY;
      end
   end

   // Latch only moves on explicit writes or context restore, never on a push or a plain return
   always_comb begin
      latch_d = latch_q;
      if (op == OP_RETURN_FROM_INTERRUPT) begin
         latch_d = ctx_q.latch[6:0];
      end else if (latch_we) begin
         latch_d = latch_wdata[6:0];
      end else if (wr_ok && (widx == IDX_PC_LATCH)) begin
         latch_d = wbyte_q[6:0];
      end
   end

   // Write zero to clear; a fault in the same cycle wins over the clear
   always_comb begin
      pwr_d = pwr_q;
      if (wr_ok && (widx == IDX_POWER_CTRL)) begin
         pwr_d = pwr_q & wbyte_q[1:0];
      end
      if (ovf) begin
         pwr_d[POS_OVF] = 1'b1;
      end
      if (unf) begin
         pwr_d[POS_UNF] = 1'b1;
      end
   end

   always_comb begin
      ctx_d = ctx_q;
      if (op == OP_VECTOR) begin
         ctx_d = ctx_in;
         ctx_d.latch = {1'b0, latch_q};
      end else if (wr_ctx) begin
         case (widx)
            IDX_FLAGS_COPY: ctx_d.flags = wbyte_q;
            IDX_ACCUM_COPY: ctx_d.accum = wbyte_q;
            IDX_BANK_COPY: ctx_d.bank = wbyte_q;
            IDX_LATCH_COPY: ctx_d.latch = wbyte_q;
            IDX_PTR0L_COPY: ctx_d.ptr0[7:0] = wbyte_q;
            IDX_PTR0H_COPY: ctx_d.ptr0[15:8] = wbyte_q;
            IDX_PTR1L_COPY: ctx_d.ptr1[7:0] = wbyte_q;
            IDX_PTR1H_COPY: ctx_d.ptr1[15:8] = wbyte_q;
            default: ctx_d = ctx_q;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_q <= PC_RESET;
         latch_q <= LATCH_RESET;
         idx_q <= STACK_EMPTY;
         pwr_q <= PWR_RESET;
         opt_q <= CFG_RESET;
         ctx_q <= CTX_RESET;
         restore_q <= 1'b0;
         fault_q <= 1'b0;
      end else begin
         pc_q <= pc_d;
         latch_q <= latch_d;
         idx_q <= idx_d;
         pwr_q <= pwr_d;
         ctx_q <= ctx_d;
         restore_q <= (op == OP_RETURN_FROM_INTERRUPT);
         fault_q <= fault;
         if (wr_ok && (widx == IDX_STACK_CFG)) begin
            opt_q <= wbyte_q[0];
         end
      end
   end

   // Entries are not reset: their content is undefined until first pushed
   for (genvar i = 0; i < 16; i++) begin : g_entry
      wire push_here = push && !fault && (push_idx[3:0] == 4'(i));
      wire sel_here = (idx_q[3:0] == 4'(i));
      always_ff @(posedge aclk) begin
         if (push_here) begin
            stack_q[i] <= ret_addr;
         end else if (tos_lo_wr && sel_here) begin
            stack_q[i][7:0] <= wbyte_q;
         end else if (tos_hi_wr && sel_here) begin
            stack_q[i][14:8] <= wbyte_q[6:0];
         end
      end
   end

   assign pc = pc_q;
   assign pc_high_latch = latch_q;
   assign ctx_out = ctx_q;
   assign ctx_restore = restore_q;
   assign stack_fault_reset = fault_q;

   always_comb begin
      rd_word = 32'h0000_0000;
      case (araddr[13:2])
         IDX_FLAGS_COPY: rd_word[7:0] = ctx_q.flags;
         IDX_ACCUM_COPY: rd_word[7:0] = ctx_q.accum;
         IDX_BANK_COPY: rd_word[7:0] = ctx_q.bank;
         IDX_LATCH_COPY: rd_word[7:0] = ctx_q.latch;
         IDX_PTR0L_COPY: rd_word[7:0] = ctx_q.ptr0[7:0];
         IDX_PTR0H_COPY: rd_word[7:0] = ctx_q.ptr0[15:8];
         IDX_PTR1L_COPY: rd_word[7:0] = ctx_q.ptr1[7:0];
         IDX_PTR1H_COPY: rd_word[7:0] = ctx_q.ptr1[15:8];
         IDX_STACK_INDEX: rd_word[4:0] = idx_q;
         IDX_TOS_LOW: rd_word[7:0] = tos_word[7:0];
         IDX_TOS_HIGH: rd_word[6:0] = tos_word[14:8];
         IDX_PC_LOW: rd_word[7:0] = pc_q[7:0];
         IDX_PC_LATCH: rd_word[6:0] = latch_q;
         IDX_POWER_CTRL: rd_word[1:0] = pwr_q;
         IDX_STACK_CFG: rd_word[0] = opt_q;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         bvalid_q <= 1'b0;
         rvalid_q <= 1'b0;
         awaddr_q <= 16'h0000;
         wbyte_q <= 8'h00;
         lane0_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else begin
         if (aw_take) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= awaddr;
         end
         if (w_take) begin
            w_hold_q <= 1'b1;
            wbyte_q <= wdata[7:0];
            lane0_q <= wstrb[0];
         end
         if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_DECERR;
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
         if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= is_mapped(araddr) ? rd_word : 32'h0000_0000;
            rresp_q <= is_mapped(araddr) ? RESP_OKAY : RESP_DECERR;
         end else if (rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // Indirect window: data memory answers in the taking cycle, flash one cycle later
   wire [15:0] ia = ind_req.addr;
   wire in_flash = ia[15];
   wire in_trad = (ia <= TRAD_LAST);
   wire in_lin = (ia >= LIN_BASE) && (ia <= LIN_LAST);
   wire [11:0] lin_off = 12'(ia - LIN_BASE);
   wire [4:0] lin_bank = 5'(lin_off / GPR_LEN);
   wire [6:0] lin_col = 7'(lin_off - 12'(12'(lin_bank) * GPR_LEN));
   wire lin_impl = in_lin && (lin_bank < LIN_BANKS_IMPL);
   wire self_win = in_trad && ((ia[6:0] == WINDOW0) || (ia[6:0] == WINDOW1));
   wire mem_ok = (in_trad && !self_win) || lin_impl;
   wire ind_take = ind_req.valid && ind_ready;
   assign ind_ready = (ind_state_q == IND_IDLE);
   assign mem_addr = in_lin ? {lin_bank, 7'(GPR_BASE + lin_col)} : ia[11:0];
   assign mem_we = ind_take && ind_req.write && mem_ok;
   assign mem_wdata = ind_req.wdata;
   assign flash_addr = flash_addr_q;
   assign ind_done = ind_done_q;
   assign ind_rdata = ind_rdata_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ind_state_q <= IND_IDLE;
         ind_done_q <= 1'b0;
         ind_rdata_q <= 8'h00;
         flash_wr_q <= 1'b0;
         flash_addr_q <= 15'h0000;
      end else begin
         ind_done_q <= 1'b0;
         case (ind_state_q)
            IND_IDLE: begin
               if (ind_take && in_flash) begin
                  ind_state_q <= IND_FLASH;
                  flash_addr_q <= ia[14:0];
                  flash_wr_q <= ind_req.write;
               end else if (ind_take) begin
                  ind_done_q <= 1'b1;
                  ind_rdata_q <= (mem_ok && !ind_req.write) ? mem_rdata : 8'h00;
               end
            end
            IND_FLASH: begin
               ind_state_q <= IND_IDLE;
               ind_done_q <= 1'b1;
               ind_rdata_q <= flash_wr_q ? 8'h00 : flash_rdata[7:0];
            end
            default: ind_state_q <= IND_IDLE;
         endcase
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_PC_RESET: assert property ($rose(aresetn) |-> pc_q == PC_RESET)
      else $error("program counter not clear after reset");
   AST_WRITE_LOW: assert property (op == OP_WRITE_LOW
      |=> pc_q == {$past(latch_q), $past(op_arg[7:0])})
      else $error("low byte write did not load latch bits");
   AST_CALL: assert property (op == OP_CALL && !fault
      |=> pc_q == {$past(latch_q[6:3]), $past(op_arg[10:0])})
      else $error("call target wrong");
   AST_CALL_VIA_ACCUM: assert property (op == OP_CALL_VIA_ACCUM && !fault
      |=> pc_q == {$past(latch_q), $past(accum)})
      else $error("accumulator call target wrong");
   AST_BRW: assert property (op == OP_BRW
      |=> pc_q == 15'($past(pc_q) + 15'h0001 + {7'h00, $past(accum)}))
      else $error("accumulator branch target wrong");
   AST_BRA: assert property (op == OP_BRA
      |=> pc_q == 15'($past(pc_q) + 15'h0001 + $past(bra_ofs)))
      else $error("operand branch target wrong");
   AST_LATCH_HOLD: assert property ((op == OP_CALL || op == OP_RETURN) && !latch_we
      && !(wr_ok && widx == IDX_PC_LATCH) |=> $stable(latch_q))
      else $error("latch moved on push or pop");
   AST_PUSH_STORE: assert property (push && !fault
      |=> idx_q == $past(push_idx) && stack_q[idx_q[3:0]] == $past(ret_addr))
      else $error("push did not store at incremented index");
   AST_EMPTY: assert property (pop && idx_q == STACK_FIRST |=> idx_q == STACK_EMPTY)
      else $error("last pop did not empty the stack");
   AST_CIRCULAR: assert property (ovf && !opt_q |=> idx_q == STACK_FIRST)
      else $error("circular overflow index wrong");
   AST_FLAGS: assert property ((ovf || unf)
      |=> (pwr_q & $past({unf, ovf})) == $past({unf, ovf}))
      else $error("stack fault flag not set");
   AST_FAULT_RESET: assert property (fault
      |=> stack_fault_reset && pc_q == PC_RESET && idx_q == STACK_EMPTY ##1 !stack_fault_reset)
      else $error("stack fault reset missing");
   AST_SELF_WINDOW: assert property (ind_take && self_win
      |-> !mem_we ##1 ind_done && ind_rdata == 8'h00)
      else $error("window through window not suppressed");
   AST_FLASH_EXTRA: assert property (ind_take && in_flash
      |-> !mem_we ##1 !ind_done ##1 ind_done)
      else $error("flash access timing wrong");
   AST_CTX_SAVE: assert property (op == OP_VECTOR
      |=> ctx_q.accum == $past(ctx_in.accum) && ctx_q.latch[6:0] == $past(latch_q))
      else $error("context not saved on vectoring");
endmodule
`default_nettype wire

//--- dv/core_mem_model.sv
`default_nettype none
module core_mem_model (
   input wire logic aclk,
   input wire logic [11:0] mem_addr,
   input wire logic mem_we,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata,
   input wire logic [14:0] flash_addr,
   output logic [13:0] flash_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ram [0:4095];
   // Seeded from the low address byte so a wrong low address byte shows up as a wrong byte
   initial begin
      for (int i = 0; i < 4096; i++) begin
         ram[i] = 8'(i) ^ 8'h5A;
      end
   end
   assign mem_rdata = ram[mem_addr];
   // Upper bits differ from the low byte, so a truncation slip is visible
   assign flash_rdata = {flash_addr[13:8], flash_addr[7:0] ^ 8'hC3};
   always @(posedge aclk) begin
      if (mem_we) begin
         ram[mem_addr] <= mem_wdata;
      end
   end
endmodule
`default_nettype wire

//--- dv/pc_stack_indirect_addressing_tb.sv
`default_nettype none
module pc_stack_indirect_addressing_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pcstk_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   pc_op_t op = OP_NONE;
   logic [14:0] op_arg = '0;
   logic [7:0] accum = '0;
   logic latch_we = 1'h0;
   logic [7:0] latch_wdata = '0;
   ctx_t ctx_in = '{flags: 8'h05, accum: 8'hC6, bank: 8'h1D, latch: 8'h00,
      ptr0: 16'h2468, ptr1: 16'h8ACE};
   ctx_t ctx_out;
   logic [14:0] pc, flash_addr;
   logic [6:0] pc_high_latch;
   logic ctx_restore, stack_fault_reset, ind_ready, ind_done, mem_we;
   ind_req_t ind_req = '0;
   logic [7:0] ind_rdata, mem_wdata, mem_rdata;
   logic [11:0] mem_addr, madr;
   logic [13:0] flash_rdata;
   logic [15:0] awaddr = '0, araddr = '0;
   logic [2:0] awprot = '0, arprot = '0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   int error_cnt = 0, n_compared = 0, cycles = 0;

   pc_stack_indirect_addressing dut (.aclk, .aresetn, .op, .op_arg, .accum, .latch_we,
      .latch_wdata, .ctx_in, .pc, .pc_high_latch, .ctx_out, .ctx_restore, .stack_fault_reset,
      .ind_req, .ind_ready, .ind_done, .ind_rdata, .mem_addr, .mem_we, .mem_wdata, .mem_rdata,
      .flash_addr, .flash_rdata, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready);
   core_mem_model mem (.aclk, .mem_addr, .mem_we, .mem_wdata, .mem_rdata, .flash_addr,
      .flash_rdata);

   always #2 aclk = ~aclk;

   task automatic conclude();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Whole run is a few hundred cycles; the ceiling only catches a hang
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         error_cnt++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [3:0] s = 4'hF);
      @(posedge aclk);
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= {24'h0, d};
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
      end while ((awvalid && awready !== 1'h1) || (wvalid && wready !== 1'h1));
      do @(posedge aclk); while (bvalid !== 1'h1);
      bready <= 1'h0;
      chk(bresp, RESP_OKAY);
   endtask

   task automatic rd(input logic [11:0] idx, input logic [7:0] exp,
      input logic [1:0] resp = RESP_OKAY);
      @(posedge aclk);
      araddr <= {2'h0, idx, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge aclk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      do @(posedge aclk); while (rvalid !== 1'h1);
      rready <= 1'h0;
      chk(rdata, {24'h0, exp});
      chk(rresp, resp);
   endtask

   task automatic core(input pc_op_t o, input logic [14:0] a = '0, input logic [7:0] w = '0);
      @(posedge aclk);
      op <= o;
      op_arg <= a;
      accum <= w;
      @(posedge aclk);
      op <= OP_NONE;
      #1;
   endtask

   task automatic ind(input logic w, input logic [15:0] a, input logic [7:0] d,
      input logic [7:0] exp, input logic we);
      int n;
      n = 0;
      @(posedge aclk);
      ind_req <= '{valid: 1'h1, write: w, addr: a, wdata: d};
      do @(posedge aclk); while (ind_ready !== 1'h1);
      ind_req <= '0;
      madr = mem_addr;
      chk(mem_we, we);
      do begin
         @(posedge aclk);
         n++;
      end while (ind_done !== 1'h1 && n < 4);
      chk(n, a[15] ? 2 : 1);
      if (!w) chk(ind_rdata, exp);
   endtask

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      #1;
      chk(pc, PC_RESET);
      chk(pc_high_latch, LATCH_RESET);
      rd(IDX_STACK_INDEX, 8'h1F);
      rd(IDX_FLAGS_COPY, 8'h00);
      wr(IDX_ACCUM_COPY, 8'h5C);
      wr(IDX_ACCUM_COPY, 8'hEE, 4'h0);
      rd(IDX_ACCUM_COPY, 8'h5C);
      rd(IDX_UNUSED, 8'h00, RESP_DECERR);
      @(posedge aclk);
      latch_we <= 1'h1;
      latch_wdata <= 8'hB5;
      @(posedge aclk);
      latch_we <= 1'h0;
      core(OP_WRITE_LOW, 15'h0012);
      chk(pc, 15'h3512);
      rd(IDX_PC_LOW, 8'h12);
      core(OP_CALL, 15'h7456);
      chk(pc, 15'h3456);
      chk(pc_high_latch, 7'h35);
      rd(IDX_STACK_INDEX, 8'h00);
      rd(IDX_TOS_LOW, 8'h13);
      rd(IDX_TOS_HIGH, 8'h35);
      core(OP_CALL_VIA_ACCUM, '0, 8'h77);
      chk(pc, 15'h3577);
      core(OP_BRW, '0, 8'hF0);
      chk(pc, 15'h3668);
      core(OP_BRA, 15'h0180);
      chk(pc, 15'h35E9);
      core(OP_RETURN);
      chk(pc, 15'h3457);
      chk(pc_high_latch, 7'h35);
      core(OP_RETURN_WITH_LITERAL);
      chk(pc, 15'h3513);
      rd(IDX_STACK_INDEX, STACK_EMPTY);
      core(OP_RETURN);
      rd(IDX_POWER_CTRL, 8'h02);
      rd(IDX_STACK_INDEX, 8'h0F);
      // Entry 15 was never pushed, so the counter needs a known value again
      core(OP_WRITE_LOW, 15'h0000);
      chk(pc, 15'h3500);
      wr(IDX_POWER_CTRL, 8'h00);
      wr(IDX_STACK_INDEX, STACK_EMPTY);
      for (int i = 0; i < 17; i++) core(OP_VECTOR, 15'h1000 + 15'(i));
      chk(pc, 15'h1010);
      rd(IDX_STACK_INDEX, 8'h00);
      rd(IDX_POWER_CTRL, 8'h01);
      rd(IDX_TOS_LOW, 8'h0F);
      rd(IDX_TOS_HIGH, 8'h10);
      rd(IDX_ACCUM_COPY, 8'hC6);
      wr(IDX_TOS_LOW, 8'h44);
      core(OP_RETURN_FROM_INTERRUPT);
      chk(pc, 15'h1044);
      chk(ctx_restore, 1'h1);
      chk(ctx_out.ptr1, ctx_in.ptr1);
      wr(IDX_POWER_CTRL, 8'h00);
      wr(IDX_STACK_CFG, 8'h01);
      core(OP_RETURN);
      chk(stack_fault_reset, 1'h1);
      chk(pc, PC_RESET);
      rd(IDX_POWER_CTRL, 8'h02);
      rd(IDX_STACK_INDEX, STACK_EMPTY);
      wr(IDX_PC_LATCH, 8'h12);
      rd(IDX_PC_LATCH, 8'h12);
      wr(IDX_PC_LOW, 8'h34);
      chk(pc, 15'h1234);
      core(OP_STEP);
      chk(pc, 15'h1235);
      ind(1'h0, 16'h0123, 8'h00, 8'h79, 1'h0);
      chk(madr, 12'h123);
      ind(1'h1, 16'h0050, 8'hAB, 8'h00, 1'h1);
      ind(1'h0, 16'h0050, 8'h00, 8'hAB, 1'h0);
      ind(1'h0, 16'h204F, 8'h00, 8'h35, 1'h0);
      chk(madr, 12'h06F);
      ind(1'h0, 16'h2050, 8'h00, 8'hFA, 1'h0);
      chk(madr, 12'h0A0);
      ind(1'h0, 16'h29AF, 8'h00, 8'h00, 1'h0);
      ind(1'h1, 16'h0081, 8'h11, 8'h00, 1'h0);
      ind(1'h0, 16'h0100, 8'h00, 8'h00, 1'h0);
      ind(1'h0, 16'h8123, 8'h00, 8'hE0, 1'h0);
      ind(1'h1, 16'h8050, 8'h99, 8'h00, 1'h0);
      conclude();
   end
endmodule
`default_nettype wire
